// ---- rtl/bus_exception_ctrl.sv ----
// External bus control, halt, wait, interrupt entry and restart sequencing.
// Assumes an execution core on the user side that issues bus requests
// and supplies its registers; memories and peripherals sit on the pins.
`timescale 1ns/1ps
`default_nettype none

module bus_exception_ctrl
(
	input  wire logic                  clock_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  stop_request_n_i,
	input  wire logic                  maskable_irq_n_i,
	input  wire logic                  nonmaskable_irq_n_i,
	input  wire logic                  onchip_ram_enable_i,
	input  wire logic [7:0]            data_i,
	output logic      [7:0]            data_o,
	output logic                       data_oe_o,
	output logic      [15:0]           addr_o,
	output logic                       read_write_n_o,
	output logic                       valid_addr_strobe_o,
	output logic                       bus_released_o,
	output logic                       bus_phase_clock_o,
	input  wire exc_pkg::bus_req_type  core_req_i,
	input  wire exc_pkg::cpu_regs_type core_regs_i,
	input  wire logic                  core_swi_i,
	input  wire logic                  core_wait_i,
	input  wire logic                  core_cc_wr_i,
	input  wire logic                  core_mask_val_i,
	output logic                       core_take_o,
	output exc_pkg::rd_ret_type        core_rd_o,
	output exc_pkg::ctx_load_type      core_ctx_o,
	output logic      [7:0]            ccr_o
);

	////////////////////////////////////////////////////////////////////////
	exc_pkg::seq_state_type state_ff;
	exc_pkg::seq_state_type nxt_state;
	logic [1:0]  phase_ff;
	logic [15:0] addr_ff;
	logic [15:0] nxt_addr;
	logic [15:0] vec_ff;
	logic [15:0] nxt_vec;
	logic [7:0]  wdata_ff;
	logic [7:0]  nxt_wdata;
	logic [7:0]  pc_hi_ff;
	logic [2:0]  cnt_ff;
	logic [2:0]  nxt_cnt;
	logic        vma_ff;
	logic        nxt_vma;
	logic        rw_n_ff;
	logic        nxt_rw_n;
	logic        core_cyc_ff;
	logic        nxt_core;
	logic        last_ff;
	logic        nxt_last;
	logic        mask_ff;
	logic        nmi_smp_ff;
	logic        irq_smp_ff;
	logic        nmi_pend_ff;
	logic        irq_latch_ff;
	logic        cyc_end;
	logic        boundary;
	logic        irq_act;
	logic        go_int;
	logic [15:0] go_vec;
	logic        set_mask;
	logic        ram_sel;
	logic [7:0]  rd_byte;
	logic [7:0]  ram_ff [exc_pkg::RAM_DEPTH];
	exc_pkg::rd_ret_type   rd_ff;
	exc_pkg::ctx_load_type ctx_ff;

	function automatic logic is_ram(input logic [15:0] a);
		is_ram = (a <= exc_pkg::RAM_LAST);
	endfunction

	function automatic logic [7:0] stack_byte(input logic [2:0] idx, input exc_pkg::cpu_regs_type r,
		input logic m);
		case (idx)
			3'h0: stack_byte = r.pc[7:0];
			3'h1: stack_byte = r.pc[15:8];
			3'h2: stack_byte = r.ix[7:0];
			3'h3: stack_byte = r.ix[15:8];
			3'h4: stack_byte = r.acc_a;
			3'h5: stack_byte = r.acc_b;
			default: stack_byte = {exc_pkg::CC_TOP_ONES, r.cc[5], m, r.cc[3:0]};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus phase clock: low for phases 0-1, high for 2-3
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			phase_ff <= 2'h0;
		else
			phase_ff <= phase_ff + 2'h1;
	end

	assign cyc_end           = (phase_ff == exc_pkg::PH_LAST);
	assign bus_phase_clock_o = phase_ff[1];

	// Inputs sampled once per cycle in the high phase
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			nmi_smp_ff <= 1'b1;
			irq_smp_ff <= 1'b1;
		end
		else if (phase_ff == exc_pkg::PH_E_RISE)
		begin
			nmi_smp_ff <= nonmaskable_irq_n_i;
			irq_smp_ff <= maskable_irq_n_i;
		end
	end

	// Edge request kept until taken; a new edge wins over the clear
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			nmi_pend_ff <= 1'b0;
		else if (phase_ff == exc_pkg::PH_E_RISE && nmi_smp_ff && !nonmaskable_irq_n_i)
			nmi_pend_ff <= 1'b1;
		else if (cyc_end && go_int && go_vec == exc_pkg::VEC_NMI)
			nmi_pend_ff <= 1'b0;
	end

	// Level request seen during halt is held so it is not lost on release
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_latch_ff <= 1'b0;
		else if (state_ff == exc_pkg::S_HALT && !irq_smp_ff)
			irq_latch_ff <= 1'b1;
		else if (cyc_end && go_int && go_vec == exc_pkg::VEC_IRQ)
			irq_latch_ff <= 1'b0;
	end

	assign irq_act  = !irq_smp_ff || irq_latch_ff;
	assign boundary = !core_cyc_ff || last_ff;

	// Mask: set by restart and entry, set wins over a software write
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mask_ff <= 1'b1;
		else if (cyc_end && set_mask)
			mask_ff <= 1'b1;
		else if (core_cc_wr_i)
			mask_ff <= core_mask_val_i;
	end

	assign ccr_o = {exc_pkg::CC_TOP_ONES, core_regs_i.cc[5], mask_ff, core_regs_i.cc[3:0]};

	////////////////////////////////////////////////////////////////////////
	// Next bus cycle, decided at the end of the current one
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_addr    = addr_ff;
		nxt_vma     = 1'b0;
		nxt_rw_n    = 1'b1;
		nxt_wdata   = wdata_ff;
		nxt_cnt     = cnt_ff;
		nxt_vec     = vec_ff;
		nxt_core    = 1'b0;
		nxt_last    = 1'b0;
		core_take_o = 1'b0;
		go_int      = 1'b0;
		go_vec      = exc_pkg::VEC_IRQ;
		set_mask    = 1'b0;
		case (state_ff)
			exc_pkg::S_BOOT:
			begin
				// Nothing else is looked at until the vector is in
				nxt_state = exc_pkg::S_VECHI;
				nxt_vec   = exc_pkg::VEC_RST;
				nxt_addr  = exc_pkg::VEC_RST;
				nxt_vma   = 1'b1;
			end
			exc_pkg::S_RUN, exc_pkg::S_HALT:
			begin
				if (state_ff == exc_pkg::S_RUN && !boundary)
					nxt_state = exc_pkg::S_RUN;
				else if (!stop_request_n_i)
				begin
					nxt_state = exc_pkg::S_HALT;
					nxt_addr  = core_regs_i.pc;
				end
				else if (nmi_pend_ff)
				begin
					go_int = 1'b1;
					go_vec = exc_pkg::VEC_NMI;
				end
				else if (irq_act && !mask_ff)
					go_int = 1'b1;
				else if (core_swi_i)
				begin
					go_int = 1'b1;
					go_vec = exc_pkg::VEC_SWI;
				end
				else if (core_wait_i)
				begin
					nxt_state = exc_pkg::S_WAIT;
					nxt_addr  = core_regs_i.pc;
				end
				else
					nxt_state = exc_pkg::S_RUN;
				if (nxt_state == exc_pkg::S_RUN && !go_int && core_req_i.valid)
				begin
					core_take_o = cyc_end;
					nxt_core    = 1'b1;
					nxt_last    = core_req_i.last;
					nxt_addr    = core_req_i.addr;
					nxt_vma     = 1'b1;
					nxt_rw_n    = !core_req_i.write;
					nxt_wdata   = core_req_i.wdata;
				end
			end
			exc_pkg::S_WAIT:
			begin
				nxt_addr = core_regs_i.pc;
				if (nmi_pend_ff)
				begin
					go_int = 1'b1;
					go_vec = exc_pkg::VEC_NMI;
				end
				else if (irq_act && !mask_ff)
					go_int = 1'b1;
			end
			exc_pkg::S_STACK:
			begin
				nxt_vma = 1'b1;
				if (cnt_ff == exc_pkg::STACK_LAST)
				begin
					set_mask  = 1'b1;
					nxt_state = exc_pkg::S_VECHI;
					nxt_addr  = vec_ff;
				end
				else
				begin
					nxt_cnt   = cnt_ff + 3'h1;
					nxt_addr  = core_regs_i.sp - {13'h0000, nxt_cnt};
					nxt_rw_n  = 1'b0;
					nxt_wdata = stack_byte(nxt_cnt, core_regs_i, mask_ff);
				end
			end
			exc_pkg::S_VECHI:
			begin
				nxt_state = exc_pkg::S_VECLO;
				nxt_addr  = vec_ff + 16'h0001;
				nxt_vma   = 1'b1;
			end
			exc_pkg::S_VECLO:
				nxt_state = exc_pkg::S_RUN;
			default:
				nxt_state = exc_pkg::S_BOOT;
		endcase
		if (go_int)
		begin
			nxt_state = exc_pkg::S_STACK;
			nxt_vec   = go_vec;
			nxt_cnt   = 3'h0;
			nxt_addr  = core_regs_i.sp;
			nxt_vma   = 1'b1;
			nxt_rw_n  = 1'b0;
			nxt_wdata = stack_byte(3'h0, core_regs_i, mask_ff);
		end
	end

	// Address, strobe, direction and write data change only as the phase clock falls
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_ff    <= exc_pkg::S_BOOT;
			addr_ff     <= exc_pkg::ADDR_RESET;
			vma_ff      <= 1'b0;
			rw_n_ff     <= 1'b1;
			wdata_ff    <= 8'h00;
			cnt_ff      <= 3'h0;
			vec_ff      <= exc_pkg::VEC_RST;
			core_cyc_ff <= 1'b0;
			last_ff     <= 1'b0;
		end
		else if (cyc_end)
		begin
			state_ff    <= nxt_state;
			addr_ff     <= nxt_addr;
			vma_ff      <= nxt_vma;
			rw_n_ff     <= nxt_rw_n;
			wdata_ff    <= nxt_wdata;
			cnt_ff      <= nxt_cnt;
			vec_ff      <= nxt_vec;
			core_cyc_ff <= nxt_core;
			last_ff     <= nxt_last;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign ram_sel = vma_ff && is_ram(addr_ff) && onchip_ram_enable_i;
	assign rd_byte = ram_sel ? ram_ff[addr_ff[6:0]] : data_i;

	always_ff @(posedge clock_i)
	begin
		if (cyc_end && ram_sel && !rw_n_ff)
			ram_ff[addr_ff[6:0]] <= wdata_ff;
	end

	// Read data and vector capture at the end of the high phase
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_ff    <= '0;
			ctx_ff   <= '0;
			pc_hi_ff <= 8'h00;
		end
		else
		begin
			rd_ff.valid <= cyc_end && core_cyc_ff && rw_n_ff;
			ctx_ff.load <= cyc_end && state_ff == exc_pkg::S_VECLO;
			if (cyc_end && core_cyc_ff && rw_n_ff)
				rd_ff.data <= rd_byte;
			if (cyc_end && state_ff == exc_pkg::S_VECHI)
				pc_hi_ff <= rd_byte;
			if (cyc_end && state_ff == exc_pkg::S_VECLO)
			begin
				ctx_ff.pc <= {pc_hi_ff, rd_byte};
				ctx_ff.sp <= (vec_ff == exc_pkg::VEC_RST) ? core_regs_i.sp : core_regs_i.sp - exc_pkg::STACK_SIZE;
			end
		end
	end

	assign core_rd_o  = rd_ff;
	assign core_ctx_o = ctx_ff;

	// Data drivers and the valid strobe are off whenever the bus is released; the address keeps driving the PC
	assign addr_o              = addr_ff;
	assign valid_addr_strobe_o = vma_ff;
	assign read_write_n_o      = rw_n_ff;
	assign bus_released_o      = (state_ff == exc_pkg::S_HALT) || (state_ff == exc_pkg::S_WAIT);
	assign data_oe_o           = vma_ff && ((!rw_n_ff && phase_ff[1]) || ram_sel);
	assign data_o              = (ram_sel && rw_n_ff) ? ram_ff[addr_ff[6:0]] : wdata_ff;

	////////////////////////////////////////////////////////////////////////
	property p_ram_drive;
		@(posedge clock_i) disable iff (!rst_n_i)
		(vma_ff && addr_ff <= exc_pkg::RAM_LAST && onchip_ram_enable_i) |-> data_oe_o;
	endproperty
	a_ram_drive: assert property (p_ram_drive) else $error("internal RAM access without bus drive");

	property p_halt_outputs;
		@(posedge clock_i) disable iff (!rst_n_i)
		$rose(bus_released_o) |-> !valid_addr_strobe_o && read_write_n_o && !data_oe_o && addr_o == $past(core_regs_i.pc);
	endproperty
	a_halt_outputs: assert property (p_halt_outputs) else $error("released bus outputs not idle");

	property p_rw_idle;
		@(posedge clock_i) disable iff (!rst_n_i)
		!valid_addr_strobe_o |-> read_write_n_o;
	endproperty
	a_rw_idle: assert property (p_rw_idle) else $error("write level with no valid address");

	property p_released_quiet;
		@(posedge clock_i) disable iff (!rst_n_i)
		bus_released_o |-> !data_oe_o && !valid_addr_strobe_o;
	endproperty
	a_released_quiet: assert property (p_released_quiet) else $error("driver on while released");

	property p_wait_exit;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == exc_pkg::S_WAIT && cyc_end && nmi_pend_ff) |=> state_ff == exc_pkg::S_STACK
			&& vec_ff == exc_pkg::VEC_NMI;
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("wait not left on interrupt");

	sequence s_fetch_hi;
		(addr_o == exc_pkg::VEC_RST && valid_addr_strobe_o && read_write_n_o) [*4];
	endsequence
	sequence s_fetch_lo;
		addr_o == exc_pkg::ADDR_RESET && valid_addr_strobe_o && read_write_n_o;
	endsequence
	property p_restart_fetch;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == exc_pkg::S_BOOT && cyc_end) |=> s_fetch_hi ##1 s_fetch_lo ##4 core_ctx_o.load;
	endproperty
	a_restart_fetch: assert property (p_restart_fetch) else $error("restart vector fetch wrong");

	property p_mask_on_entry;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == exc_pkg::S_STACK && cnt_ff == exc_pkg::STACK_LAST && cyc_end) |=> mask_ff
			&& addr_o == vec_ff;
	endproperty
	a_mask_on_entry: assert property (p_mask_on_entry) else $error("mask not set after stacking");

	property p_nmi_first;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == exc_pkg::S_RUN && cyc_end && boundary && stop_request_n_i && nmi_pend_ff && irq_act)
			|=> vec_ff == exc_pkg::VEC_NMI;
	endproperty
	a_nmi_first: assert property (p_nmi_first) else $error("maskable served before non-maskable");

	property p_entry_low_phase;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == exc_pkg::S_STACK && $changed(state_ff)) |-> !bus_phase_clock_o ##2 bus_phase_clock_o;
	endproperty
	a_entry_low_phase: assert property (p_entry_low_phase) else $error("entry not in low phase");

	property p_masked_irq;
		@(posedge clock_i) disable iff (!rst_n_i)
		(cyc_end && mask_ff && !nmi_pend_ff && !core_swi_i && state_ff == exc_pkg::S_RUN)
			|=> state_ff != exc_pkg::S_STACK;
	endproperty
	a_masked_irq: assert property (p_masked_irq) else $error("masked request taken");

endmodule

`default_nettype wire

// ---- rtl/exc_pkg.sv ----
// Constants and types for the bus and exception sequencer.
// Assumes one 100 MHz clock; the bus phase clock is four clocks long.
package exc_pkg;
	localparam logic [15:0] VEC_IRQ    = 16'hfff8;
	localparam logic [15:0] VEC_SWI    = 16'hfffa;
	localparam logic [15:0] VEC_NMI    = 16'hfffc;
	localparam logic [15:0] VEC_RST    = 16'hfffe;
	localparam logic [15:0] ADDR_RESET = 16'hffff;
	localparam logic [15:0] RAM_LAST   = 16'h007f;
	localparam int          RAM_DEPTH  = 128;
	localparam int          CC_MASK_BIT = 4;
	localparam logic [1:0]  CC_TOP_ONES = 2'h3;
	localparam logic [1:0]  PH_E_RISE  = 2'h2;
	localparam logic [1:0]  PH_LAST    = 2'h3;
	localparam logic [2:0]  STACK_LAST = 3'h6;
	localparam logic [15:0] STACK_SIZE = 16'h0007;

	typedef enum logic [2:0]
	{
		S_BOOT  = 3'b000,
		S_RUN   = 3'b001,
		S_STACK = 3'b010,
		S_VECHI = 3'b011,
		S_VECLO = 3'b100,
		S_HALT  = 3'b101,
		S_WAIT  = 3'b110
	} seq_state_type;

	typedef struct packed
	{
		logic        valid;
		logic        last;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bus_req_type;

	typedef struct packed
	{
		logic [15:0] pc;
		logic [15:0] ix;
		logic [15:0] sp;
		logic [7:0]  acc_a;
		logic [7:0]  acc_b;
		logic [5:0]  cc;
	} cpu_regs_type;

	typedef struct packed
	{
		logic        load;
		logic [15:0] pc;
		logic [15:0] sp;
	} ctx_load_type;

	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} rd_ret_type;
endpackage

// ---- test/sys_memory.sv ----
// Behavioural memory and peripherals on the pin side of the bus controller.
// Assumes the bench resolves the shared data bus from both output enables.
`timescale 1ns/1ps
`default_nettype none

module sys_memory
#(
	parameter int ACC_NS = 3
)
(
	input  wire logic        clock_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        rw_n_i,
	input  wire logic        vma_i,
	input  wire logic        e_i,
	input  wire logic        ram_en_i,
	input  wire logic [7:0]  bus_i,
	output logic      [7:0]  rd_o,
	output logic             oe_o
);
	logic [7:0] mem [0:65535];
	logic       hit;

	initial
	begin
		for (int a = 0; a < 65536; a++)
			mem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
	end

	////////////////////////////////////////////////////////////
	// Low range stays off while the internal RAM answers
	assign hit = ram_en_i && (addr_i <= 16'h007f);
	// Access delay models a slower device than the clock edge
	assign #(ACC_NS) oe_o = vma_i && rw_n_i && e_i && !hit;
	assign #(ACC_NS) rd_o = mem[addr_i];

	// Last sample while E is high wins, so early garbage is overwritten
	always @(posedge clock_i)
	begin
		if (e_i && vma_i && !rw_n_i && !hit)
			mem[addr_i] <= bus_i;
	end
endmodule

`default_nettype wire

// ---- test/bus_exception_ctrl_test.sv ----
// Self-checking bench for the bus and exception sequencer.
// Assumes sys_memory on the pins and the bench acting as execution core.
`timescale 1ns/1ps
`default_nettype none

module bus_exception_ctrl_test;
	logic                  clock_i, rst_n_i, stop_n, irq_n, nmi_n, ram_en;
	logic                  data_oe_o, rw_n, valid_addr_strobe, released, e_clk, take, took;
	logic                  mem_oe, swi, wt, ccwr, mval, mask_exp;
	logic [7:0]            data_o, bus, mem_q, ccr;
	logic [7:0]            bus_ff = 8'h00;
	logic [15:0]           addr, a;
	exc_pkg::bus_req_type  req;
	exc_pkg::cpu_regs_type regs;
	exc_pkg::rd_ret_type   rd;
	exc_pkg::ctx_load_type ctx;
	logic [7:0]            shadow [int];
	int                    failures, cmp_count, seed, loads;

	bus_exception_ctrl i_bus_exception_ctrl
	(
		.clock_i(clock_i), .rst_n_i(rst_n_i), .stop_request_n_i(stop_n),
		.maskable_irq_n_i(irq_n), .nonmaskable_irq_n_i(nmi_n), .onchip_ram_enable_i(ram_en),
		.data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o), .addr_o(addr),
		.read_write_n_o(rw_n), .valid_addr_strobe_o(valid_addr_strobe), .bus_released_o(released),
		.bus_phase_clock_o(e_clk), .core_req_i(req), .core_regs_i(regs), .core_swi_i(swi),
		.core_wait_i(wt), .core_cc_wr_i(ccwr), .core_mask_val_i(mval), .core_take_o(take),
		.core_rd_o(rd), .core_ctx_o(ctx), .ccr_o(ccr)
	);

	sys_memory i_sys_memory
	(
		.clock_i(clock_i), .addr_i(addr), .rw_n_i(rw_n), .vma_i(valid_addr_strobe), .e_i(e_clk),
		.ram_en_i(ram_en), .bus_i(bus), .rd_o(mem_q), .oe_o(mem_oe)
	);

	// Released bus shows the inverse of its last level
	assign bus = data_oe_o ? data_o : (mem_oe ? mem_q : ~bus_ff);
	always @(posedge clock_i)
	begin
		bus_ff <= bus;
		took <= take;
		loads <= loads + int'(ctx.load === 1'b1);
	end

	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	////////////////////////////////////////////////////////////
	task automatic cmp_bit(string n, logic e, logic s);
		cmp_count++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s expected %b seen %b", n, e, s);
		end
	endtask

	task automatic cmp_word(string n, logic [15:0] e, logic [15:0] s);
		cmp_count++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [7:0] init_val(logic [15:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5a;
	endfunction

	function automatic logic [7:0] exp_rd(logic [15:0] x);
		return shadow.exists(int'(x)) ? shadow[int'(x)] : init_val(x);
	endfunction

	task automatic core_cycle(logic wr, logic [15:0] x, logic [7:0] d);
		logic hit;
		hit = ram_en && (x <= 16'h007f);
		req = '{1'b1, 1'b1, wr, x, d};
		repeat (400)
		begin
			@(negedge clock_i);
			if (took)
				break;
		end
		req.valid = 1'b0;
		cmp_word("addr", x, addr);
		cmp_bit("rw_n", !wr, rw_n);
		cmp_bit("vma", 1'b1, valid_addr_strobe);
		cmp_bit("data_oe", hit, data_oe_o);
		if (wr)
		begin
			shadow[int'(x)] = d;
			// Valid must not drop and rise again in one time step
			@(negedge clock_i);
		end
		else
		begin
			repeat (8)
			begin
				@(negedge clock_i);
				if (rd.valid === 1'b1)
					break;
			end
			cmp_bit("rd_valid", 1'b1, rd.valid);
			cmp_word("rd_data", {8'h00, exp_rd(x)}, {8'h00, rd.data});
		end
	endtask

	task automatic expect_entry(logic [15:0] v, logic stacked);
		logic [15:0] sp;
		logic [7:0]  st [7];
		sp = regs.sp;
		st = '{regs.pc[7:0], regs.pc[15:8], regs.ix[7:0], regs.ix[15:8], regs.acc_a, regs.acc_b,
			{2'b11, regs.cc[5], mask_exp, regs.cc[3:0]}};
		repeat (300)
		begin
			@(negedge clock_i);
			if (ctx.load === 1'b1)
				break;
		end
		cmp_bit("ctx_load", 1'b1, ctx.load);
		cmp_word("vector", {init_val(v), init_val(v + 16'h0001)}, ctx.pc);
		cmp_word("sp", stacked ? sp - 16'h0007 : sp, ctx.sp);
		for (int k = 0; k < 7 && stacked; k++)
		begin
			cmp_word("stack", {8'h00, st[k]}, {8'h00, i_sys_memory.mem[sp - 16'(k)]});
			shadow[int'(sp - 16'(k))] = st[k];
		end
		mask_exp = 1'b1;
		cmp_bit("mask", 1'b1, ccr[4]);
		cmp_word("ccr_top", 16'h0003, {14'h0000, ccr[7:6]});
		regs.pc = ctx.pc;
		regs.sp = ctx.sp;
		// Lets the load counter take the pulse before callers read it
		@(negedge clock_i);
	endtask

	task automatic set_mask(logic m);
		ccwr = 1'b1;
		mval = m;
		@(negedge clock_i);
		ccwr = 1'b0;
		mask_exp = m;
	endtask

	task automatic wait_rel(logic v);
		repeat (60)
		begin
			@(negedge clock_i);
			if (released === v)
				break;
		end
		cmp_bit("released", v, released);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial
	begin
		#400000;
		failures++;
		wrap_up();
	end

	initial
	begin
		int n;
		seed = 56026;
		failures = 0;
		cmp_count = 0;
		loads = 0;
		{stop_n, nmi_n, ram_en, swi, wt, ccwr, mval, mask_exp} = 8'hc1;
		rst_n_i = 1'b0;
		irq_n = 1'b0; // Pending across release
		req = '0;
		regs = '{16'h4000, 16'h1357, 16'h0400, 8'h12, 8'h34, 6'h2b};
		repeat (4) @(negedge clock_i); // Held low four cycles
		cmp_word("rst_addr", 16'hffff, addr);
		cmp_bit("rst_vma", 1'b0, valid_addr_strobe);
		cmp_bit("rst_rw", 1'b1, rw_n);
		rst_n_i = 1'b1; // Clean single rise
		expect_entry(exc_pkg::VEC_RST, 1'b0);
		n = loads;
		core_cycle(1'b1, 16'h0200, 8'h3c); // Masked request stays unserved
		cmp_word("loads", 16'(n), 16'(loads));
		irq_n = 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			ram_en = $random(seed);
			a = $random(seed);
			a = a[0] ? {9'h000, a[7:1]} : 16'h0100 | (a & 16'h0fff);
			n = $random(seed);
			core_cycle(1'b1, a, n[7:0]);
			core_cycle(1'b0, a, 8'h00);
		end
		set_mask(1'b0);
		cmp_bit("mask_clr", 1'b0, ccr[4]);
		irq_n = 1'b0;
		expect_entry(exc_pkg::VEC_IRQ, 1'b1);
		irq_n = 1'b1;
		set_mask(1'b0);
		irq_n = 1'b0;
		nmi_n = 1'b0;
		expect_entry(exc_pkg::VEC_NMI, 1'b1);
		irq_n = 1'b1;
		nmi_n = 1'b1;
		swi = 1'b1;
		expect_entry(exc_pkg::VEC_SWI, 1'b1);
		swi = 1'b0;
		set_mask(1'b0);
		stop_n = 1'b0;
		wait_rel(1'b1);
		cmp_bit("halt_vma", 1'b0, valid_addr_strobe);
		cmp_bit("halt_rw", 1'b1, rw_n);
		cmp_bit("halt_oe", 1'b0, data_oe_o);
		cmp_word("halt_addr", regs.pc, addr);
		// Single step: release for one bus cycle, set well before E falls
		@(posedge e_clk);
		@(negedge clock_i);
		req = '{1'b1, 1'b1, 1'b0, 16'h0300, 8'h00};
		stop_n = 1'b1;
		repeat (2) @(negedge clock_i);
		req.valid = 1'b0;
		cmp_bit("step_take", 1'b1, took);
		cmp_bit("step_run", 1'b0, released);
		repeat (2) @(negedge clock_i);
		stop_n = 1'b0;
		wait_rel(1'b1);
		cmp_word("step_addr", regs.pc, addr);
		n = loads;
		irq_n = 1'b0;
		repeat (12) @(negedge clock_i);
		irq_n = 1'b1;
		repeat (8) @(negedge clock_i);
		cmp_bit("halt_hold", 1'b1, released);
		cmp_word("halt_loads", 16'(n), 16'(loads));
		stop_n = 1'b1;
		expect_entry(exc_pkg::VEC_IRQ, 1'b1);
		cmp_bit("run", 1'b0, released);
		wt = 1'b1;
		wait_rel(1'b1);
		wt = 1'b0;
		cmp_bit("wait_vma", 1'b0, valid_addr_strobe);
		nmi_n = 1'b0;
		expect_entry(exc_pkg::VEC_NMI, 1'b1);
		nmi_n = 1'b1;
		cmp_bit("wait_done", 1'b0, released);
		core_cycle(1'b0, 16'h0200, 8'h00);
		wrap_up();
	end
endmodule

`default_nettype wire
